// file: logic/addr_step.sv
// address stepping by item size for one side of a transfer
`timescale 1ns/1ps
module addr_step (
   input wire logic [31:0] addr,
   input wire logic [1:0] size,
   input wire logic inc,
   output logic [31:0] next
);
   // size code n means 2**n bytes per item
   assign next = inc ? addr + (dma_pkg::ADDR_ONE << size) : addr;
endmodule : addr_step

// file: logic/dma_event_core.sv
// seven channel dma mover with width conversion and event flags
`timescale 1ns/1ps
module dma_event_core (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [6:0] periph_req,
   input wire logic cfg_write,
   input wire logic [2:0] cfg_ch,
   input wire logic [14:0] cfg_word,
   input wire logic [15:0] cfg_count,
   input wire logic [31:0] cfg_mem_addr,
   input wire logic [31:0] cfg_per_addr,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic [1:0] htrans,
   output logic [31:0] haddr,
   output logic [2:0] hsize,
   output logic hwrite,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   output logic [6:0] ch_irq,
   output logic [6:0] ch_enabled
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RADDR = 5'b00010,
      S_RDATA = 5'b00100,
      S_WADDR = 5'b01000,
      S_WDATA = 5'b10000
   } mover_t;

   typedef struct packed {
      mover_t st;
      logic [dma_pkg::NCH-1:0][dma_pkg::CFG_W-1:0] cfg;
      logic [dma_pkg::NCH-1:0][31:0] mbase;
      logic [dma_pkg::NCH-1:0][31:0] pbase;
      logic [dma_pkg::NCH-1:0][31:0] mcur;
      logic [dma_pkg::NCH-1:0][31:0] pcur;
      logic [dma_pkg::NCH-1:0][dma_pkg::CNT_W-1:0] total;
      logic [dma_pkg::NCH-1:0][dma_pkg::CNT_W-1:0] remain;
      logic [dma_pkg::NCH-1:0][dma_pkg::FLAGS_PER_CH-1:0] flags;
      logic [2:0] ch;
      logic [31:0] data;
      logic [31:0] rdata;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic [1:0] hsize;
      logic hwrite;
   } core_t;

   core_t core_r;
   core_t core_nxt;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [1:0] size_of(
      input logic [dma_pkg::CFG_W-1:0] c,
      input logic mem_side
   );
      size_of = mem_side ? c[dma_pkg::C_MEM_SIDE_ITEM_SIZE +: 2] : c[dma_pkg::C_PERIPH_SIDE_ITEM_SIZE +: 2];
   endfunction : size_of

   function automatic logic inc_of(
      input logic [dma_pkg::CFG_W-1:0] c,
      input logic mem_side
   );
      inc_of = mem_side ? c[dma_pkg::C_MEM_SIDE_INCREMENT] : c[dma_pkg::C_PERIPH_SIDE_INCREMENT];
   endfunction : inc_of

   ////////////////////////////////////////////////////////////////////////
   // channel view: source and destination picked by the direction bit
   logic [2:0] pick;
   logic pick_valid;
   logic [2:0] sel_ch;
   logic [dma_pkg::CFG_W-1:0] sel_cfg;
   logic dir;
   logic [1:0] src_size;
   logic [1:0] dst_size;
   logic src_inc;
   logic dst_inc;
   logic [31:0] src_addr;
   logic [31:0] dst_addr;
   logic [31:0] src_next;
   logic [31:0] dst_next;
   logic [31:0] packed_item;
   logic [31:0] status;

   // fixed priority, lowest channel first; full arbitration lives outside
   always_comb begin
      pick = 3'h0;
      pick_valid = 1'b0;
      for (int i = dma_pkg::NCH - 1; i >= 0; i--) begin
         if (core_r.cfg[i][dma_pkg::C_EN] && core_r.remain[i] != '0 &&
             (periph_req[i] || core_r.cfg[i][dma_pkg::C_M2M])) begin
            pick = 3'(i);
            pick_valid = 1'b1;
         end
      end
   end

   assign sel_ch = (core_r.st == S_IDLE) ? pick : core_r.ch;
   assign sel_cfg = core_r.cfg[sel_ch];
   assign dir = sel_cfg[dma_pkg::C_DIR];
   assign src_size = size_of(sel_cfg, dir);
   assign src_inc = inc_of(sel_cfg, dir);
   assign src_addr = dir ? core_r.mcur[sel_ch] : core_r.pcur[sel_ch];
   assign dst_size = size_of(sel_cfg, !dir);
   assign dst_inc = inc_of(sel_cfg, !dir);
   assign dst_addr = dir ? core_r.pcur[sel_ch] : core_r.mcur[sel_ch];

   addr_step u_src_step (
      .addr(src_addr),
      .size(src_size),
      .inc(src_inc),
      .next(src_next)
   );

   addr_step u_dst_step (
      .addr(dst_addr),
      .size(dst_size),
      .inc(dst_inc),
      .next(dst_next)
   );

   lane_pack u_lane_pack (
      .rdata(hrdata),
      .lane(src_addr[1:0]),
      .src_size(src_size),
      .dst_size(dst_size),
      .wdata(packed_item)
   );

   assign status = {{dma_pkg::STATUS_RSVD_W{1'b0}}, core_r.flags};

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [dma_pkg::NCH-1:0] ev_err;
      logic [dma_pkg::NCH-1:0] ev_half;
      logic [dma_pkg::NCH-1:0] ev_done;
      logic [31:0] clr;
      logic [3:0] cc;
      logic [3:0] f;
      logic [dma_pkg::CNT_W-1:0] left;
      logic [dma_pkg::CFG_W-1:0] keep;
      ev_err = '0;
      ev_half = '0;
      ev_done = '0;
      clr = '0;
      cc = '0;
      f = '0;
      left = '0;
      keep = '0;
      core_nxt = core_r;

      // register port: reads answer next cycle, unmapped reads give zero
      if (reg_sel && !reg_write) begin
         core_nxt.rdata = (reg_addr == dma_pkg::STATUS_OFF) ? status : '0;
      end
      if (reg_sel && reg_write && reg_addr == dma_pkg::CLEAR_OFF) begin
         clr = reg_wdata;
      end

      // mover: one item at a time, read phase then write phase
      unique case (core_r.st)
         S_IDLE: begin
            if (pick_valid) begin
               core_nxt.ch = pick;
               if (src_size == dma_pkg::SZ_RSVD ||
                   dst_size == dma_pkg::SZ_RSVD) begin
                  ev_err[pick] = 1'b1;
               end else begin
                  core_nxt.htrans = dma_pkg::HTRANS_NONSEQ;
                  core_nxt.haddr = src_addr;
                  core_nxt.hsize = src_size;
                  core_nxt.hwrite = 1'b0;
                  core_nxt.st = S_RADDR;
               end
            end
         end
         S_RADDR: begin
            if (hready) begin
               core_nxt.htrans = dma_pkg::HTRANS_IDLE;
               core_nxt.st = S_RDATA;
            end
         end
         S_RDATA: begin
            if (hready) begin
               if (hresp == dma_pkg::HRESP_ERROR) begin
                  ev_err[core_r.ch] = 1'b1;
                  core_nxt.st = S_IDLE;
               end else begin
                  core_nxt.data = packed_item;
                  core_nxt.htrans = dma_pkg::HTRANS_NONSEQ;
                  core_nxt.haddr = dst_addr;
                  core_nxt.hsize = dst_size;
                  core_nxt.hwrite = 1'b1;
                  core_nxt.st = S_WADDR;
               end
            end
         end
         S_WADDR: begin
            if (hready) begin
               core_nxt.htrans = dma_pkg::HTRANS_IDLE;
               core_nxt.st = S_WDATA;
            end
         end
         S_WDATA: begin
            if (hready) begin
               core_nxt.hwrite = 1'b0;
               core_nxt.st = S_IDLE;
               if (hresp == dma_pkg::HRESP_ERROR) begin
                  ev_err[core_r.ch] = 1'b1;
               end else begin
                  // each side steps by its own increment bit and item size, both in this cycle
                  if (dir) begin
                     core_nxt.mcur[core_r.ch] = src_next;
                     core_nxt.pcur[core_r.ch] = dst_next;
                  end else begin
                     core_nxt.pcur[core_r.ch] = src_next;
                     core_nxt.mcur[core_r.ch] = dst_next;
                  end
                  left = core_r.remain[core_r.ch] - 1'b1;
                  core_nxt.remain[core_r.ch] = left;
                  if (left == core_r.total[core_r.ch] >> 1) begin
                     ev_half[core_r.ch] = 1'b1;
                  end
                  if (left == '0) begin
                     ev_done[core_r.ch] = 1'b1;
                     if (sel_cfg[dma_pkg::C_CIRC]) begin
                        core_nxt.remain[core_r.ch] = core_r.total[core_r.ch];
                        core_nxt.mcur[core_r.ch] = core_r.mbase[core_r.ch];
                        core_nxt.pcur[core_r.ch] = core_r.pbase[core_r.ch];
                     end
                  end
               end
            end
         end
      endcase

      // configuration writes from the channel setup path
      if (cfg_write && cfg_ch < 3'(dma_pkg::NCH)) begin
         if (core_r.cfg[cfg_ch][dma_pkg::C_EN]) begin
            keep = dma_pkg::CFG_LOCK_MASK;
         end else begin
            core_nxt.mbase[cfg_ch] = cfg_mem_addr;
            core_nxt.pbase[cfg_ch] = cfg_per_addr;
            core_nxt.mcur[cfg_ch] = cfg_mem_addr;
            core_nxt.pcur[cfg_ch] = cfg_per_addr;
            core_nxt.total[cfg_ch] = cfg_count;
            core_nxt.remain[cfg_ch] = cfg_count;
         end
         core_nxt.cfg[cfg_ch] = (core_r.cfg[cfg_ch] & keep) |
                                (cfg_word & ~keep);
         // a pending error blocks re-enabling until it is cleared
         if (core_r.flags[cfg_ch][dma_pkg::F_ERR]) begin
            core_nxt.cfg[cfg_ch][dma_pkg::C_EN] =
               core_r.cfg[cfg_ch][dma_pkg::C_EN] &
               cfg_word[dma_pkg::C_EN];
         end
      end

      // flags: a new event wins over a clear in the same cycle
      for (int i = 0; i < dma_pkg::NCH; i++) begin
         cc = clr[i*dma_pkg::FLAGS_PER_CH +: dma_pkg::FLAGS_PER_CH];
         f = core_r.flags[i];
         if (cc[dma_pkg::F_ANY]) begin
            f = '0;
         end
         if (cc[dma_pkg::F_ERR]) begin
            f[dma_pkg::F_ERR] = 1'b0;
         end
         if (cc[dma_pkg::F_HALF]) begin
            f[dma_pkg::F_HALF] = 1'b0;
         end
         if (cc[dma_pkg::F_DONE]) begin
            f[dma_pkg::F_DONE] = 1'b0;
         end
         if ((cc[dma_pkg::F_ERR] || cc[dma_pkg::F_HALF] ||
              cc[dma_pkg::F_DONE]) &&
             f[dma_pkg::F_ERR:dma_pkg::F_DONE] == '0) begin
            f[dma_pkg::F_ANY] = 1'b0;
         end
         if (ev_err[i]) begin
            f[dma_pkg::F_ERR] = 1'b1;
            core_nxt.cfg[i][dma_pkg::C_EN] = 1'b0;
         end
         if (ev_half[i]) begin
            f[dma_pkg::F_HALF] = 1'b1;
         end
         if (ev_done[i]) begin
            f[dma_pkg::F_DONE] = 1'b1;
         end
         if (ev_err[i] || ev_half[i] || ev_done[i]) begin
            f[dma_pkg::F_ANY] = 1'b1;
         end
         core_nxt.flags[i] = f;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         core_r.st <= S_IDLE;
         core_r.cfg <= {dma_pkg::NCH{dma_pkg::CFG_RESET}};
         core_r.mbase <= '0;
         core_r.pbase <= '0;
         core_r.mcur <= '0;
         core_r.pcur <= '0;
         core_r.total <= '0;
         core_r.remain <= '0;
         core_r.flags <= '0;
         core_r.ch <= 3'h0;
         core_r.data <= '0;
         core_r.rdata <= dma_pkg::STATUS_RESET;
         core_r.haddr <= '0;
         core_r.htrans <= dma_pkg::HTRANS_IDLE;
         core_r.hsize <= dma_pkg::SZ_BYTE;
         core_r.hwrite <= 1'b0;
      end else begin
         core_r <= core_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata = core_r.rdata;
   assign htrans = core_r.htrans;
   assign haddr = core_r.haddr;
   assign hsize = {1'b0, core_r.hsize};
   assign hwrite = core_r.hwrite;
   assign hwdata = core_r.data;

   // only the three individual flags raise the line; global has no enable
   generate
      for (genvar g = 0; g < dma_pkg::NCH; g++) begin : g_irq
         assign ch_irq[g] =
            (core_r.flags[g][dma_pkg::F_ERR] &
             core_r.cfg[g][dma_pkg::C_ERR_IE]) |
            (core_r.flags[g][dma_pkg::F_HALF] &
             core_r.cfg[g][dma_pkg::C_HALF_IE]) |
            (core_r.flags[g][dma_pkg::F_DONE] &
             core_r.cfg[g][dma_pkg::C_DONE_IE]);
         assign ch_enabled[g] = core_r.cfg[g][dma_pkg::C_EN];
      end
   endgenerate

endmodule : dma_event_core

// file: logic/dma_pkg.sv
// shared constants for the dma width, error and event flag block
package dma_pkg;

   localparam int NCH = 7;
   localparam int CFG_W = 15;
   localparam int CNT_W = 16;
   localparam int FLAGS_PER_CH = 4;
   localparam int STATUS_RSVD_W = 4;

   // register port offsets
   localparam logic [7:0] STATUS_OFF = 8'h00;
   localparam logic [7:0] CLEAR_OFF = 8'h04;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   // flag positions inside one channel nibble
   localparam int F_ANY = 0;
   localparam int F_DONE = 1;
   localparam int F_HALF = 2;
   localparam int F_ERR = 3;

   // channel_config field positions
   localparam int C_EN = 0;
   localparam int C_DONE_IE = 1;
   localparam int C_HALF_IE = 2;
   localparam int C_ERR_IE = 3;
   localparam int C_DIR = 4;
   localparam int C_CIRC = 5;
   localparam int C_PERIPH_SIDE_INCREMENT = 6;
   localparam int C_MEM_SIDE_INCREMENT = 7;
   localparam int C_PERIPH_SIDE_ITEM_SIZE = 8;
   localparam int C_MEM_SIDE_ITEM_SIZE = 10;
   localparam int C_PRIO = 12;
   localparam int C_M2M = 14;
   localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;
   // fields frozen while the channel is enabled
   localparam logic [CFG_W-1:0] CFG_LOCK_MASK = 15'h7fd0;

   // item size codes, identical to the low bits of the bus size field
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] SZ_RSVD = 2'h3;

   // master bus encodings
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_ERROR = 1'h1;
   localparam logic [31:0] ADDR_ONE = 32'h0000_0001;

endpackage : dma_pkg

// file: logic/lane_pack.sv
// source item extraction, width conversion and write lane replication
`timescale 1ns/1ps
module lane_pack (
   input wire logic [31:0] rdata,
   input wire logic [1:0] lane,
   input wire logic [1:0] src_size,
   input wire logic [1:0] dst_size,
   output logic [31:0] wdata
);
   logic [31:0] shifted;
   logic [31:0] item;

   always_comb begin
      // read data sits on the byte lanes picked by the source address
      shifted = rdata >> {lane, 3'b000};
      unique case (src_size)
         dma_pkg::SZ_BYTE: item = {{24{1'b0}}, shifted[7:0]};
         dma_pkg::SZ_HALF: item = {{16{1'b0}}, shifted[15:0]};
         dma_pkg::SZ_WORD: item = shifted;
         default: item = shifted;
      endcase
      // narrower destination keeps the low bits, copies fill idle lanes
      unique case (dst_size)
         dma_pkg::SZ_BYTE: wdata = {4{item[7:0]}};
         dma_pkg::SZ_HALF: wdata = {2{item[15:0]}};
         dma_pkg::SZ_WORD: wdata = item;
         default: wdata = item;
      endcase
   end
endmodule : lane_pack

// file: test/ahb_mem_model.sv
// far-side bus slave: answers reads, records writes, faults one region
`timescale 1ns/1ps
module ahb_mem_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic slow,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   output logic hready,
   output logic hresp,
   output logic [31:0] hrdata
);
   // reserved address space of this model, any access there faults
   localparam logic [3:0] BAD_NIB = 4'he;
   logic dp_r, dw_r, st_r;
   logic [2:0] ds_r, wr_size;
   logic [31:0] da_r, last_r, wr_addr, wr_data;
   int wr_cnt;
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[15:2], 2'h0, ~a[15:2], 2'h1} ^ 32'h5a3c_96e1;
   endfunction : word_at
   ////////////////////////////////////////////////////////////////////////
   // slow mode stretches every data phase by one wait state
   assign hready = !(slow && dp_r && !st_r);
   assign hresp = dp_r && da_r[31:28] == BAD_NIB;
   // released data bus toggles so that stale values never look valid
   assign hrdata = (dp_r && !dw_r) ? word_at(da_r) : ~last_r;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dp_r <= 1'b0;
         st_r <= 1'b0;
         wr_cnt <= 0;
         last_r <= 32'h0000_0000;
      end else begin
         st_r <= slow && dp_r && !st_r;
         last_r <= hrdata;
         if (hready) begin
            if (dp_r && dw_r && !hresp) begin
               wr_addr <= da_r;
               wr_data <= hwdata;
               wr_size <= ds_r;
               wr_cnt <= wr_cnt + 1;
            end
            dp_r <= htrans == 2'h2;
            da_r <= haddr;
            dw_r <= hwrite;
            ds_r <= hsize;
         end
      end
   end
endmodule : ahb_mem_model

// file: test/dma_event_core_chk.sv
// port assertions for the dma event core
`timescale 1ns/1ps
module dma_event_core_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hresp,
   input wire logic [6:0] ch_irq,
   input wire logic [6:0] ch_enabled
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_go(logic w);
      htrans == dma_pkg::HTRANS_NONSEQ && hwrite == w && hready;
   endsequence
   sequence s_rd_reg;
      reg_sel && !reg_write;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   property p_size_legal;
      htrans == dma_pkg::HTRANS_NONSEQ |-> hsize < 3'h3;
   endproperty
   a_size_legal: assert property (p_size_legal)
      else $error("bus access with reserved size");
   property p_rep_byte;
      s_go(1'b1) ##0 hsize == 3'h0 |=> hwdata == {4{hwdata[7:0]}};
   endproperty
   a_rep_byte: assert property (p_rep_byte)
      else $error("byte write not replicated");
   property p_rep_half;
      s_go(1'b1) ##0 hsize == 3'h1 |=> hwdata == {2{hwdata[15:0]}};
   endproperty
   a_rep_half: assert property (p_rep_half)
      else $error("half-word write not replicated");
   property p_one_phase;
      htrans == dma_pkg::HTRANS_NONSEQ && hready
         |=> htrans == dma_pkg::HTRANS_IDLE;
   endproperty
   a_one_phase: assert property (p_one_phase)
      else $error("address phase not followed by idle");
   property p_wr_after_rd;
      s_go(1'b0) |-> ##[1:12] ((htrans == dma_pkg::HTRANS_NONSEQ && hwrite)
         || hresp);
   endproperty
   a_wr_after_rd: assert property (p_wr_after_rd)
      else $error("read not followed by write or error");
   property p_err_stop;
      hresp && hready
         |-> ##[1:3] ($countones(ch_enabled) < $countones($past(ch_enabled)));
   endproperty
   a_err_stop: assert property (p_err_stop)
      else $error("bus error did not stop a channel");
   property p_rsvd_zero;
      s_rd_reg |=> reg_rdata[31:28] == 4'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved status bits not zero");
   property p_unmapped;
      s_rd_reg ##0 reg_addr != dma_pkg::STATUS_OFF |=> reg_rdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("non status read returned data");
   property p_reset_quiet;
      $rose(resetn) |-> ch_irq == '0 && ch_enabled == '0
         && htrans == dma_pkg::HTRANS_IDLE;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
endmodule : dma_event_core_chk
bind dma_event_core dma_event_core_chk chk (.clk_sys(clk_sys),
   .resetn(resetn), .reg_sel(reg_sel), .reg_write(reg_write),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .htrans(htrans),
   .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hresp(hresp), .ch_irq(ch_irq), .ch_enabled(ch_enabled));

// file: test/test_dma_event_core.sv
// random and corner tests of width conversion, errors and event flags
`timescale 1ns/1ps
module test_dma_event_core;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [6:0] periph_req = '0;
   logic cfg_write = 1'b0;
   logic [2:0] cfg_ch = '0;
   logic [14:0] cfg_word = '0;
   logic [15:0] cfg_count = '0;
   logic [31:0] cfg_mem_addr = '0, cfg_per_addr = '0, reg_wdata = '0;
   logic reg_sel = 1'b0, reg_write = 1'b0, slow = 1'b0, dir;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_rdata, haddr, hwdata, hrdata, st, sb, db;
   logic [1:0] htrans, ss, ds, inc;
   logic [2:0] hsize, ie;
   logic hwrite, hready, hresp;
   logic [6:0] ch_irq, ch_enabled;
   logic [14:0] w;
   int error_cnt = 0, n_compared = 0, seed = 21959, ch, k, i, n0;
   always #12.5 clk_sys = ~clk_sys;
   dma_event_core dut (.clk_sys(clk_sys), .resetn(resetn),
      .periph_req(periph_req), .cfg_write(cfg_write), .cfg_ch(cfg_ch),
      .cfg_word(cfg_word), .cfg_count(cfg_count),
      .cfg_mem_addr(cfg_mem_addr), .cfg_per_addr(cfg_per_addr),
      .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .htrans(htrans),
      .haddr(haddr), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata),
      .hready(hready), .hresp(hresp), .hrdata(hrdata), .ch_irq(ch_irq),
      .ch_enabled(ch_enabled));
   ahb_mem_model m (.clk_sys(clk_sys), .resetn(resetn), .slow(slow),
      .htrans(htrans), .haddr(haddr), .hsize(hsize), .hwrite(hwrite),
      .hwdata(hwdata), .hready(hready), .hresp(hresp), .hrdata(hrdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // full word accesses only; a read leaves its data in st
   task automatic rg(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_sys);
      reg_sel <= 1'b1;
      reg_write <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_sel <= 1'b0;
      #1 st = reg_rdata;
   endtask : rg
   task automatic cfg(input logic [31:0] ma, input logic [31:0] pa);
      @(posedge clk_sys);
      cfg_write <= 1'b1;
      cfg_ch <= 3'(ch);
      cfg_word <= w;
      cfg_count <= 16'h0002;
      cfg_mem_addr <= ma;
      cfg_per_addr <= pa;
      @(posedge clk_sys);
      cfg_write <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : cfg
   // bounded wait for a write count, or for the channel to stop
   task automatic wait_ev(input logic on_wr, input int n);
      for (int t = 0; t < 300 && (on_wr ? m.wr_cnt < n : ch_enabled[ch]); t++)
         @(posedge clk_sys);
      // a wait that runs out is a failure even if later compares agree
      if (on_wr ? m.wr_cnt < n : ch_enabled[ch])
         error_cnt++;
      #1;
   endtask : wait_ev
   function automatic logic [31:0] item(input logic [31:0] a);
      logic [31:0] v;
      v = m.word_at(a) >> (8 * a[1:0]);
      v = v & ~(32'hffff_ffff << (8 << ((ss < ds) ? ss : ds)));
      return ds == 2'h0 ? {4{v[7:0]}} : ds == 2'h1 ? {2{v[15:0]}} : v;
   endfunction : item
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
      check(st, dma_pkg::STATUS_RESET);
      rg(1'b0, 8'h08, 32'h0);
      check(st, 32'h0);
      for (k = 0; k < 9; k++) begin
         ss = 2'(k / 3);
         ds = 2'(k % 3);
         ch = int'($unsigned($random(seed)) % 7);
         dir = 1'($random(seed));
         ie = 3'($random(seed));
         inc = 2'($random(seed));
         slow <= 1'($random(seed));
         sb = (32'($random(seed)) & 32'h0000_fff0)
            | (32'($random(seed)) & 32'h3 & ~((32'h1 << ss) - 1));
         db = 32'($random(seed)) & 32'h0000_fff0;
         // inc[1] steps the source, inc[0] the destination
         w = {1'b0, 2'(k), dir ? ss : ds, dir ? ds : ss,
              dir ? inc : {inc[0], inc[1]}, 1'b0, dir, ie, 1'b1};
         cfg(dir ? sb : db, dir ? db : sb);
         n0 = m.wr_cnt;
         periph_req <= 7'(1 << ch);
         for (i = 0; i < 2; i++) begin
            wait_ev(1'b1, n0 + i + 1);
            check(m.wr_addr, db + i * inc[0] * (1 << ds));
            st = item(sb + i * inc[1] * (1 << ss));
            check(m.wr_data, st);
            check(32'(m.wr_size), 32'(ds));
         end
         periph_req <= '0;
         rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
         check(st[4*ch +: 4], 4'h7);
         check(ch_irq[ch], ie[0] | ie[1]);
         if (k == 0) begin
            rg(1'b1, dma_pkg::CLEAR_OFF, 32'h0);
            rg(1'b1, dma_pkg::STATUS_OFF, 32'hffff_ffff);
            rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
            check(st[4*ch +: 4], 4'h7);
         end
         if (k % 2) begin
            rg(1'b1, dma_pkg::CLEAR_OFF, 32'h2 << (4 * ch));
            rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
            check(st[4*ch +: 4], 4'h5);
            rg(1'b1, dma_pkg::CLEAR_OFF, 32'h4 << (4 * ch));
         end else
            rg(1'b1, dma_pkg::CLEAR_OFF, 32'h1 << (4 * ch));
         rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
         check(st, 32'h0);
         w = '0;
         cfg(32'h0, 32'h0);
         $display("width test %0d done", k);
      end
      // read fault, write fault, reserved size code
      for (k = 0; k < 3; k++) begin
         ch = 4 + k;
         w = k == 2 ? 15'h03c9 : k == 1 ? 15'h00c1 : 15'h00c9;
         sb = k == 0 ? 32'he000_0000 : 32'h0000_0100;
         db = k == 1 ? 32'he000_0040 : 32'h0000_0200;
         cfg(db, sb);
         check(ch_enabled[ch], 1'b1);
         periph_req <= 7'(1 << ch);
         wait_ev(1'b0, 0);
         check(ch_enabled[ch], 1'b0);
         periph_req <= '0;
         rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
         check(st[4*ch +: 4], 4'h9);
         check(ch_irq[ch], w[3]);
         cfg(db, sb);
         check(ch_enabled[ch], 1'b0);
         rg(1'b1, dma_pkg::CLEAR_OFF, 32'h8 << (4 * ch));
         rg(1'b0, dma_pkg::STATUS_OFF, 32'h0);
         check(st, 32'h0);
         check(ch_irq[ch], 1'b0);
         cfg(db, sb);
         check(ch_enabled[ch], 1'b1);
         $display("error test %0d done", k);
      end
      summarize();
   end
endmodule : test_dma_event_core
